// File: rtl/bucket_map.vh
// register offsets, reset values and timing constants of the activity monitor
`ifndef BUCKET_MAP_VH
`define BUCKET_MAP_VH
`define IDX_ALARM_SET_LIMIT_CFG3 12'h05C
`define IDX_DRAIN_SPEED_CFG2 12'h05B
`define IDX_DRAIN_SPEED_CFG3 12'h05F
`define IDX_ALARM_CLR_LIMIT_CFG3 12'h058
`define IDX_BUCKET_CAP_CFG3 12'h05E
// register indices are word indices; the byte address is four times the index
`define OFS_ALARM_SET_LIMIT_CFG3 (`IDX_ALARM_SET_LIMIT_CFG3 * 12'h004)
`define OFS_DRAIN_SPEED_CFG2 (`IDX_DRAIN_SPEED_CFG2 * 12'h004)
`define OFS_DRAIN_SPEED_CFG3 (`IDX_DRAIN_SPEED_CFG3 * 12'h004)
`define OFS_ALARM_CLR_LIMIT_CFG3 (`IDX_ALARM_CLR_LIMIT_CFG3 * 12'h004)
`define OFS_BUCKET_CAP_CFG3 (`IDX_BUCKET_CAP_CFG3 * 12'h004)
`define OFS_CFG_SELECT 12'h100
`define OFS_MONITOR_STATUS 12'h104
`define RST_ALARM_SET_LIMIT 8'h06
`define RST_DRAIN_SPEED 2'h1
`define RST_ALARM_CLR_LIMIT 8'h04
`define RST_BUCKET_CAP 8'h08
`define RST_CFG_SELECT 1'h0
`define RST_CFG_SELECT_BIT 0
`define DRAIN_W 2
`define DRAIN_128MS 2'h0
`define DRAIN_256MS 2'h1
`define DRAIN_512MS 2'h2
`define DECAY_M1_128MS 3'h0
`define DECAY_M1_256MS 3'h1
`define DECAY_M1_512MS 3'h3
`define DECAY_M1_1024MS 3'h7
`define CYCLE_MS 128
`define CLK_HZ 20000000
`define CYCLE_CLKS (`CYCLE_MS * (`CLK_HZ / 1000))
`define STAT_ALARM_BIT 8
`endif

// File: rtl/leaky_bucket_activity_monitor.v
// leaky-bucket accumulator judging reference clock activity, with apb registers
// How it works
// - bucket is evaluated and updated once at the end of every 128 ms cycle
// - a cycle with failure or erratic behaviour adds exactly one
// - fault-free cycles never add; all faults within one cycle count as one step
// - each fault-free decay period of 1, 2, 4 or 8 cycles subtracts one
// - two-bit drain code 00..11 selects 128, 256, 512 or 1024 ms per step
// - alarm rises once count reaches selected configuration's upper threshold
// - each configuration owns its own 8-bit alarm-set threshold; only cfg3's is writable, cfg2's keeps its reset value
// - active alarm clears once count falls to the lower threshold
// - count saturates at the configured bucket size
`timescale 1ns/1ps
`include "bucket_map.vh"
module leaky_bucket_activity_monitor #(
    parameter [31:0] CYCLE_CLKS = `CYCLE_CLKS
) (
    input wire clk_sys,
    input wire rst_b,
    input wire clk_en,
    input wire fault_in,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    output reg alarm,
    output reg [7:0] fill
);
    // reset enters asynchronously but leaves on the clock, two flops late
    reg rst_s1;
    reg rst_s2;
    wire rst_n = rst_s2;
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1 <= 1'b0;
            rst_s2 <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_s2 <= rst_s1;
        end
    end

    // fault flag comes from outside this clock domain
    // only fault_s2 is read by the logic; fault_s1 may still be settling
    reg fault_s1;
    reg fault_s2;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fault_s1 <= 1'b0;
            fault_s2 <= 1'b0;
        end else if (clk_en) begin
            fault_s1 <= fault_in;
            fault_s2 <= fault_s1;
        end
    end

    // configuration registers, two bucket configurations (index 0 = cfg2, 1 = cfg3)
    reg [7:0] set_limit [0:1];
    reg [7:0] clr_limit [0:1];
    reg [7:0] cap [0:1];
    reg [`DRAIN_W-1:0] drain [0:1];
    reg cfg_sel;

    // one address hit per register
    wire hit_set3 = (paddr == `OFS_ALARM_SET_LIMIT_CFG3);
    wire hit_clr3 = (paddr == `OFS_ALARM_CLR_LIMIT_CFG3);
    wire hit_cap3 = (paddr == `OFS_BUCKET_CAP_CFG3);
    wire hit_drain2 = (paddr == `OFS_DRAIN_SPEED_CFG2);
    wire hit_drain3 = (paddr == `OFS_DRAIN_SPEED_CFG3);
    wire hit_sel = (paddr == `OFS_CFG_SELECT);
    wire hit_stat = (paddr == `OFS_MONITOR_STATUS);

    // bus phases; clk_en gates every state change they cause
    wire access = psel && penable;
    wire setup = psel && !penable;
    wire wr = access && pwrite && clk_en;
    wire rd_ok = hit_set3 || hit_clr3 || hit_cap3 || hit_drain2 || hit_drain3 ||
        hit_sel || hit_stat;

    // zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;

    // unmapped addresses answer with an error and read as zero
    assign pslverr = access && !rd_ok;

    // cfg2 thresholds and size are not reachable here and keep their reset values
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : cfg
            // write strobes per configuration; cfg2 exposes only its drain speed
            wire wr_set = wr && (g == 1) && hit_set3;
            wire wr_clr = wr && (g == 1) && hit_clr3;
            wire wr_cap = wr && (g == 1) && hit_cap3;
            wire wr_drain = wr && ((g == 1) ? hit_drain3 : hit_drain2);

            always @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    set_limit[g] <= `RST_ALARM_SET_LIMIT;
                end else if (wr_set) begin
                    set_limit[g] <= pwdata[7:0];
                end
            end

            always @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    clr_limit[g] <= `RST_ALARM_CLR_LIMIT;
                end else if (wr_clr) begin
                    clr_limit[g] <= pwdata[7:0];
                end
            end

            always @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    cap[g] <= `RST_BUCKET_CAP;
                end else if (wr_cap) begin
                    cap[g] <= pwdata[7:0];
                end
            end

            always @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    drain[g] <= `RST_DRAIN_SPEED;
                end else if (wr_drain) begin
                    drain[g] <= pwdata[`DRAIN_W-1:0];
                end
            end
        end
    endgenerate

    // selects which configuration drives the bucket
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfg_sel <= `RST_CFG_SELECT;
        end else if (wr && hit_sel) begin
            cfg_sel <= pwdata[`RST_CFG_SELECT_BIT];
        end
    end

    // read word assembled combinationally, captured in the setup cycle
    // fields sit in the low bits; unused bits read zero
    reg [31:0] rd_word;
    always @* begin
        rd_word = 32'h00000000;
        case (paddr)
            `OFS_ALARM_SET_LIMIT_CFG3: begin
                rd_word[7:0] = set_limit[1];
            end
            `OFS_ALARM_CLR_LIMIT_CFG3: begin
                rd_word[7:0] = clr_limit[1];
            end
            `OFS_BUCKET_CAP_CFG3: begin
                rd_word[7:0] = cap[1];
            end
            `OFS_DRAIN_SPEED_CFG2: begin
                rd_word[`DRAIN_W-1:0] = drain[0];
            end
            `OFS_DRAIN_SPEED_CFG3: begin
                rd_word[`DRAIN_W-1:0] = drain[1];
            end
            `OFS_CFG_SELECT: begin
                rd_word[`RST_CFG_SELECT_BIT] = cfg_sel;
            end
            `OFS_MONITOR_STATUS: begin
                rd_word[7:0] = fill;
                rd_word[`STAT_ALARM_BIT] = alarm;
            end
            default: begin
                rd_word = 32'h00000000;
            end
        endcase
    end

    // a register keeps prdata steady through the whole access phase
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h00000000;
        end else if (clk_en && setup) begin
            prdata <= rd_word;
        end
    end

    // monitoring cycle timebase; one wide counter, no prescaler to keep in step
    reg [31:0] tick_cnt;
    wire tick = (tick_cnt == CYCLE_CLKS - 32'h00000001);
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt <= 32'h00000000;
        end else if (clk_en) begin
            if (tick) begin
                tick_cnt <= 32'h00000000;
            end else begin
                tick_cnt <= tick_cnt + 32'h00000001;
            end
        end
    end

    // fault seen at any time inside the current cycle
    // a fault in the tick clock itself is counted through cyc_fault
    reg seen;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            seen <= 1'b0;
        end else if (clk_en) begin
            if (tick) begin
                seen <= 1'b0;
            end else if (fault_s2) begin
                seen <= 1'b1;
            end
        end
    end

    wire cyc_fault = seen || fault_s2;

    // settings of the configuration in use
    wire [7:0] lim_set = set_limit[cfg_sel];
    wire [7:0] lim_clr = clr_limit[cfg_sel];
    wire [7:0] lim_cap = cap[cfg_sel];
    wire [`DRAIN_W-1:0] rate = drain[cfg_sel];

    // decay period in monitoring cycles, less one
    // quiet counts fault-free ticks since the last decay step
    reg [2:0] quiet;
    reg [2:0] period_m1;
    always @* begin
        case (rate)
            `DRAIN_128MS: begin
                period_m1 = `DECAY_M1_128MS;
            end
            `DRAIN_256MS: begin
                period_m1 = `DECAY_M1_256MS;
            end
            `DRAIN_512MS: begin
                period_m1 = `DECAY_M1_512MS;
            end
            default: begin
                period_m1 = `DECAY_M1_1024MS;
            end
        endcase
    end
    wire decay_due = (quiet >= period_m1);

    // bucket step for the cycle that ends now
    // a fault restarts the quiet run, so decay waits a whole period again
    reg [7:0] next_fill;
    reg [2:0] next_quiet;
    always @* begin
        next_fill = fill;
        next_quiet = quiet;
        if (cyc_fault) begin
            next_quiet = 3'h0;
            if (fill < lim_cap) begin
                next_fill = fill + 8'h01;
            end else begin
                // a lowered cap pulls an overfull bucket straight down to it
                next_fill = lim_cap;
            end
        end else if (decay_due) begin
            next_quiet = 3'h0;
            if (fill != 8'h00) begin
                next_fill = fill - 8'h01;
            end else begin
                next_fill = 8'h00;
            end
        end else begin
            next_quiet = quiet + 3'h1;
        end
    end

    // alarm with hysteresis between the two thresholds; set is tested first
    reg next_alarm;
    always @* begin
        next_alarm = alarm;
        if (next_fill >= lim_set) begin
            next_alarm = 1'b1;
        end else if (next_fill <= lim_clr) begin
            next_alarm = 1'b0;
        end
    end

    // all bucket state moves only on the cycle tick
    wire step_now = clk_en && tick;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fill <= 8'h00;
        end else if (step_now) begin
            fill <= next_fill;
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            quiet <= 3'h0;
        end else if (step_now) begin
            quiet <= next_quiet;
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            alarm <= 1'b0;
        end else if (step_now) begin
            alarm <= next_alarm;
        end
    end
endmodule

// File: test/bucket_props_properties.sv
// port checker for the leaky-bucket activity monitor
`timescale 1ns/1ps
module bucket_props #(
    parameter [31:0] CYCLE_CLKS = 16
) (
    input wire clk_sys,
    input wire rst_b,
    input wire fault_in,
    input wire psel,
    input wire penable,
    input wire pslverr,
    input wire alarm,
    input wire [7:0] fill
);
    reg [7:0] q;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // clocks since a raw fault; the margin covers the input synchroniser
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) q <= 8'hFF;
        else q <= fault_in ? 8'h00 : q + {7'h00, q != 8'hFF};
    end
    property p_step; $changed(fill) |-> fill - $past(fill) + 8'h01 <= 8'h02; endproperty
    a_step: assert property (p_step) else $error("fill step not one");
    property p_gap; $changed(fill) |=> $stable(fill) [*8]; endproperty
    a_gap: assert property (p_gap) else $error("fill updated too often");
    property p_up; fill > $past(fill) |-> q < CYCLE_CLKS + 32'h8; endproperty
    a_up: assert property (p_up) else $error("rise without fault");
    property p_set; $rose(alarm) |-> fill > $past(fill); endproperty
    a_set: assert property (p_set) else $error("alarm set without rise");
    property p_clr; $fell(alarm) |-> fill < $past(fill); endproperty
    a_clr: assert property (p_clr) else $error("alarm cleared without fall");
    property p_cap; fill <= 8'h08; endproperty
    a_cap: assert property (p_cap) else $error("fill above cap");
    property p_floor; $past(fill) == 8'h00 |-> fill != 8'hFF; endproperty
    a_floor: assert property (p_floor) else $error("fill underflow");
    property p_err; pslverr |-> psel && penable; endproperty
    a_err: assert property (p_err) else $error("error outside access");
    c_rise: cover property ($rose(alarm));
    c_fall: cover property ($fell(alarm));
    c_full: cover property (fill == 8'h08);
endmodule

// File: test/fault_src.sv
// fault source in place of the reference activity detector
`timescale 1ns/1ps
module fault_src (
    input wire clk_sys,
    input wire [1:0] mode,
    output reg fault_in = 1'b0
);
    reg [3:0] n = 4'h0;
    // mode 1 solid failure, mode 2 erratic: one short pulse each 16 clocks
    always @(posedge clk_sys) begin
        n <= n + 4'h1;
        fault_in <= mode[0] | (mode[1] & n == 4'h0);
    end
endmodule

// File: test/leaky_bucket_activity_monitor_test.sv
// self-checking bench for the leaky-bucket activity monitor
`timescale 1ns/1ps
module leaky_bucket_activity_monitor_test;
    reg clk_sys = 1'b0, rst_b = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, se;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0, rd;
    reg [1:0] mode = 2'h0;
    wire fault_in, pready, pslverr, alarm;
    wire [31:0] prdata;
    wire [7:0] fill;
    integer errors = 0, checks_done = 0, n, d;
    leaky_bucket_activity_monitor #(.CYCLE_CLKS(16)) DUT (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .fault_in(fault_in),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .alarm(alarm),
        .fill(fill)
    );
    fault_src model (
        .clk_sys(clk_sys),
        .mode(mode),
        .fault_in(fault_in)
    );
    initial forever #25 clk_sys = ~clk_sys;
    task end_sim;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("FAIL at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task bail;
        errors = errors + 1;
        end_sim;
    endtask
    task xfer(input w, input [11:0] a, input [31:0] v);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n = n + 1;
        end while (pready !== 1'b1 && n < 20);
        if (n == 20) bail;
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // waits edge by edge; n ends as the clocks spent
    task wf(input [7:0] v);
        n = 0;
        while (fill !== v && n < 400) begin
            @(posedge clk_sys);
            #1 n = n + 1;
        end
        if (n == 400) bail;
    endtask
    task sm(input [1:0] m);
        @(posedge clk_sys);
        mode <= m;
    endtask
    initial begin
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk_sys);
        xfer(1'h0, 12'h170, 32'h0);
        chk(rd, 32'h06);
        xfer(1'h0, 12'h16C, 32'h0);
        chk(rd, 32'h01);
        xfer(1'h0, 12'h200, 32'h0);
        chk(se, 32'h1);
        chk(rd, 32'h0);
        xfer(1'h1, 12'h100, 32'h1);
        xfer(1'h1, 12'h160, 32'h1);
        xfer(1'h1, 12'h170, 32'h3);
        xfer(1'h1, 12'h178, 32'h5);
        xfer(1'h1, 12'h17C, 32'h0);
        sm(2'h2);
        wf(8'h02);
        chk(alarm, 32'h0);
        wf(8'h03);
        chk(alarm, 32'h1);
        wf(8'h05);
        xfer(1'h0, 12'h104, 32'h0);
        chk(rd, 32'h105);
        sm(2'h0);
        wf(8'h02);
        chk(alarm, 32'h1);
        wf(8'h01);
        chk(alarm, 32'h0);
        repeat (99) @(posedge clk_sys);
        #1 chk(fill, 32'h0);
        // clock enable low freezes the bucket even under a solid fault
        @(posedge clk_sys);
        clk_en <= 1'b0;
        mode <= 2'h1;
        repeat (60) @(posedge clk_sys);
        #1 chk(fill, 32'h0);
        sm(2'h0);
        repeat (4) @(posedge clk_sys);
        clk_en <= 1'b1;
        for (d = 0; d < 4; d = d + 1) begin
            xfer(1'h1, 12'h17C, d);
            sm(2'h1);
            wf(8'h05);
            sm(2'h0);
            wf(8'h04);
            wf(8'h03);
            chk(n, 32'h10 << d);
        end
        // drain rate first, so the new configuration never sits on a slow decay
        xfer(1'h1, 12'h16C, 32'h0);
        xfer(1'h1, 12'h100, 32'h0);
        wf(8'h00);
        xfer(1'h1, 12'h16C, 32'hFF);
        xfer(1'h0, 12'h16C, 32'h0);
        chk(rd, 32'h3);
        sm(2'h1);
        wf(8'h05);
        chk(alarm, 32'h0);
        wf(8'h06);
        chk(alarm, 32'h1);
        repeat (99) @(posedge clk_sys);
        #1 chk(fill, 32'h8);
        end_sim;
    end
endmodule
bind leaky_bucket_activity_monitor bucket_props #(.CYCLE_CLKS(CYCLE_CLKS)) props (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .fault_in(fault_in),
    .psel(psel),
    .penable(penable),
    .pslverr(pslverr),
    .alarm(alarm),
    .fill(fill)
);
